//--- hdl/wpc_pkg.sv
package wpc_pkg;

	// Register offsets: printed offsets are not all multiples of four, so they are indices.
	localparam logic [7:0] IDX_PA_LEVEL   = 8'h21;
	localparam logic [7:0] IDX_PB_LEVEL   = 8'h22;
	localparam logic [7:0] IDX_PC_LEVEL   = 8'h23;
	localparam logic [7:0] IDX_PD_LEVEL   = 8'h24;
	localparam logic [7:0] IDX_PE_LEVEL   = 8'h25;
	localparam logic [7:0] IDX_SRC_EN     = 8'h26;
	localparam logic [7:0] IDX_PA_ENABLE  = 8'h27;
	localparam logic [7:0] IDX_PB_ENABLE  = 8'h28;
	localparam logic [7:0] IDX_PC_ENABLE  = 8'h29;
	localparam logic [7:0] IDX_PD_ENABLE  = 8'h2a;
	localparam logic [7:0] IDX_PE_ENABLE  = 8'h2b;
	localparam logic [7:0] IDX_CAUSE      = 8'h44;
	localparam logic [7:0] IDX_DIG_WAKE   = 8'h6e;
	localparam logic [7:0] IDX_PWR_DOWN_A = 8'h05;
	localparam logic [7:0] IDX_PWR_DOWN_B = 8'h06;
	localparam logic [7:0] IDX_MODE       = 8'h50;

	// Reset values.
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_PWR_DOWN_A = 8'he0;
	localparam logic [7:0] RST_PWR_DOWN_B = 8'hdf;

	// Field positions.
	localparam int SRC_IO_BIT     = 4;
	localparam int SRC_DIG_BIT    = 5;
	localparam int SRC_TIMER_BIT  = 6;
	localparam int CAUSE_TIMER    = 1;
	localparam int CAUSE_DIG      = 2;
	localparam int CAUSE_IO       = 3;
	localparam int DW_I2C         = 0;
	localparam int DW_SPI         = 1;
	localparam int DW_USB         = 2;
	localparam int DW_GPIO        = 3;
	localparam int DW_SYNC_I2C    = 4;
	localparam int DW_REMOTE      = 5;
	localparam int DW_RESUME      = 6;
	localparam int DW_RESET       = 7;
	localparam int PDA_ANA_LDO    = 4;
	localparam int PDA_BBPLL_LDO  = 7;
	localparam int PDB_ADC        = 0;
	localparam int PDB_LNA_LDO    = 1;
	localparam int NUM_PINS       = 36;

	// Timing: length of the USB resume drive.
	localparam int RESUME_US      = 1000;
	localparam int CLK_MHZ        = 50;
	localparam int RESUME_CYCLES  = RESUME_US * CLK_MHZ;

	// Power modes.
	typedef enum logic [1:0] {
		WPC_ACTIVE  = 2'b00,
		WPC_SUSPEND = 2'b01,
		WPC_DEEP    = 2'b10
	} wpc_mode_t;

	// Signals that leave toward the analog modules.
	typedef struct packed {
		logic [7:0] pwr_down_a;
		logic [7:0] pwr_down_b;
		logic       core_ldo_off;
		logic       boost_converter_off;
	} wpc_power_t;

	// Wake outcome toward the system.
	typedef struct packed {
		logic wake;
		logic reset_on_wake;
	} wpc_wake_t;

endpackage : wpc_pkg

//--- hdl/wpc_top.sv
`timescale 1ns/10ps
module wpc_top #(
	parameter int RESUME_LEN = wpc_pkg::RESUME_CYCLES
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          hsel_i,
	input  wire logic [31:0]                   haddr_i,
	input  wire logic [1:0]                    htrans_i,
	input  wire logic                          hwrite_i,
	input  wire logic [2:0]                    hsize_i,
	input  wire logic [31:0]                   hwdata_i,
	input  wire logic                          hready_i,
	output logic      [31:0]                   hrdata_o,
	output logic                               hreadyout_o,
	output logic                               hresp_o,
	input  wire logic [wpc_pkg::NUM_PINS-1:0]  wake_pins_i,
	input  wire logic                          usb_resume_i,
	input  wire logic                          timer_expired_i,
	input  wire logic                          host_wake_i2c_i,
	input  wire logic                          host_wake_spi_i,
	input  wire logic                          host_wake_sync_i2c_i,
	input  wire logic                          gpio_wake_i,
	output logic                               usb_resume_drive_o,
	output logic                               remote_wake_en_o,
	output wpc_pkg::wpc_power_t                power_o,
	output wpc_pkg::wpc_wake_t                 wake_o,
	output wpc_pkg::wpc_mode_t                 mode_o
);
	import wpc_pkg::*;

	logic [7:0]          level_reg [5];
	logic [7:0]          pin_en_reg [5];
	logic [7:0]          src_en_reg;
	logic [7:0]          cause_reg;
	logic [7:0]          dig_reg;
	logic [7:0]          pda_reg;
	logic [7:0]          pdb_reg;
	wpc_mode_t           mode_reg;
	logic                wr_pend_reg;
	logic                rd_pend_reg;
	logic [7:0]          idx_reg;
	logic [31:0]         rdata_reg;
	logic [NUM_PINS-1:0] pin_s1_reg;
	logic [NUM_PINS-1:0] pin_s2_reg;
	logic [4:0]          ext_s1_reg;
	logic [4:0]          ext_s2_reg;
	logic [31:0]         resume_cnt_reg;
	logic                wake_reg;
	logic [NUM_PINS-1:0] pin_level;
	logic [NUM_PINS-1:0] pin_en;
	logic [NUM_PINS-1:0] pin_hit;
	logic                io_wake;
	logic                timer_wake;
	logic                usb_wake;
	logic                dig_wake;
	logic                wake_next;
	logic                addr_phase;
	logic [7:0]          idx_next;
	logic [7:0]          rd_next;

	// Address phase of a valid transfer.
	assign addr_phase = hsel_i & hready_i & htrans_i[1];
	assign idx_next   = haddr_i[9:2];

	// AHB bus: zero wait states, always OKAY.
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rdata_reg;

	// Address phase capture.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			idx_reg     <= RST_ZERO;
		end else begin
			wr_pend_reg <= addr_phase & hwrite_i;
			rd_pend_reg <= addr_phase & ~hwrite_i;
			idx_reg     <= idx_next;
		end
	end

	// Read multiplexer; unmapped indices read zero.
	always_comb begin
		rd_next = RST_ZERO;
		case (idx_next)
			IDX_PA_LEVEL:   rd_next = level_reg[0];
			IDX_PB_LEVEL:   rd_next = level_reg[1];
			IDX_PC_LEVEL:   rd_next = level_reg[2];
			IDX_PD_LEVEL:   rd_next = level_reg[3];
			IDX_PE_LEVEL:   rd_next = {4'h0, level_reg[4][3:0]};
			IDX_SRC_EN:     rd_next = src_en_reg;
			IDX_PA_ENABLE:  rd_next = pin_en_reg[0];
			IDX_PB_ENABLE:  rd_next = pin_en_reg[1];
			IDX_PC_ENABLE:  rd_next = pin_en_reg[2];
			IDX_PD_ENABLE:  rd_next = pin_en_reg[3];
			IDX_PE_ENABLE:  rd_next = {4'h0, pin_en_reg[4][3:0]};
			IDX_CAUSE:      rd_next = cause_reg;
			IDX_DIG_WAKE:   rd_next = dig_reg;
			IDX_PWR_DOWN_A: rd_next = pda_reg;
			IDX_PWR_DOWN_B: rd_next = pdb_reg;
			IDX_MODE:       rd_next = {6'h00, mode_reg};
			default:        rd_next = RST_ZERO;
		endcase
	end

	// Read data registered at the address phase, valid in the data phase.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (addr_phase & ~hwrite_i) begin
			rdata_reg <= {24'h00_0000, rd_next};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 5; i++) begin
				level_reg[i]  <= RST_ZERO;
				pin_en_reg[i] <= RST_ZERO;
			end
		end else if (wr_pend_reg) begin
			for (int i = 0; i < 5; i++) begin
				if (idx_reg == IDX_PA_LEVEL + 8'(i)) begin
					level_reg[i] <= (i == 4) ? {4'h0, hwdata_i[3:0]} : hwdata_i[7:0];
				end
				if (idx_reg == IDX_PA_ENABLE + 8'(i)) begin
					pin_en_reg[i] <= (i == 4) ? {4'h0, hwdata_i[3:0]} : hwdata_i[7:0];
				end
			end
		end
	end

	// Source enables and the digital wake control.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			src_en_reg <= RST_ZERO;
			dig_reg    <= RST_ZERO;
		end else if (wr_pend_reg) begin
			if (idx_reg == IDX_SRC_EN) begin
				src_en_reg <= hwdata_i[7:0];
			end
			if (idx_reg == IDX_DIG_WAKE) begin
				dig_reg <= hwdata_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pda_reg <= RST_PWR_DOWN_A;
			pdb_reg <= RST_PWR_DOWN_B;
		end else if (wr_pend_reg) begin
			if (idx_reg == IDX_PWR_DOWN_A) begin
				pda_reg <= hwdata_i[7:0];
			end
			if (idx_reg == IDX_PWR_DOWN_B) begin
				pdb_reg <= hwdata_i[7:0];
			end
		end
	end

	// Pin and event synchronisers.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			ext_s1_reg <= 5'h00;
			ext_s2_reg <= 5'h00;
		end else begin
			pin_s1_reg <= wake_pins_i;
			pin_s2_reg <= pin_s1_reg;
			ext_s1_reg <= {usb_resume_i, timer_expired_i, host_wake_i2c_i,
			               host_wake_spi_i, host_wake_sync_i2c_i};
			ext_s2_reg <= ext_s1_reg;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			assign pin_level[g] = level_reg[g / 8][g % 8];
			assign pin_en[g]    = pin_en_reg[g / 8][g % 8];
			assign pin_hit[g]   = pin_en[g] & (pin_s2_reg[g] == pin_level[g]);
		end
	endgenerate

	assign io_wake    = src_en_reg[SRC_IO_BIT] & (|pin_hit) & (mode_reg != WPC_ACTIVE);
	assign timer_wake = src_en_reg[SRC_TIMER_BIT] & ext_s2_reg[3] & (mode_reg != WPC_ACTIVE);
	assign usb_wake   = dig_reg[DW_USB] & src_en_reg[SRC_DIG_BIT] & ext_s2_reg[4]
	                  & (mode_reg == WPC_SUSPEND);
	assign dig_wake   = usb_wake | ((src_en_reg[SRC_DIG_BIT] & (mode_reg == WPC_SUSPEND))
	                  & ((dig_reg[DW_I2C] & ext_s2_reg[2]) | (dig_reg[DW_SPI] & ext_s2_reg[1])
	                  | (dig_reg[DW_SYNC_I2C] & ext_s2_reg[0])
	                  | ((dig_reg[DW_GPIO] | dig_reg[DW_REMOTE]) & gpio_wake_i)));
	assign wake_next  = io_wake | timer_wake | dig_wake;
	assign remote_wake_en_o = dig_reg[DW_REMOTE];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cause_reg <= RST_ZERO;
		end else begin
			if (wr_pend_reg && idx_reg == IDX_CAUSE) begin
				cause_reg <= (cause_reg & ~hwdata_i[7:0])
				           | {4'h0, io_wake, dig_wake, timer_wake, 1'b0};
			end else begin
				cause_reg <= cause_reg | {4'h0, io_wake, dig_wake, timer_wake, 1'b0};
			end
		end
	end

	// Power mode: software enters sleep, any wake returns to active.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= WPC_ACTIVE;
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= wake_next;
			if (wake_next) begin
				mode_reg <= WPC_ACTIVE;
			end else if (wr_pend_reg && idx_reg == IDX_MODE) begin
				case (hwdata_i[1:0])
					2'b01:   mode_reg <= WPC_SUSPEND;
					2'b10:   mode_reg <= WPC_DEEP;
					default: mode_reg <= WPC_ACTIVE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			resume_cnt_reg <= 32'h0000_0000;
		end else if (wr_pend_reg && idx_reg == IDX_DIG_WAKE && hwdata_i[DW_RESUME]) begin
			resume_cnt_reg <= 32'(RESUME_LEN);
		end else if (resume_cnt_reg != 32'h0000_0000) begin
			resume_cnt_reg <= resume_cnt_reg - 32'h0000_0001;
		end
	end
	assign usb_resume_drive_o = (resume_cnt_reg != 32'h0000_0000);

	assign power_o.pwr_down_a          = pda_reg;
	assign power_o.pwr_down_b          = pdb_reg;
	assign power_o.core_ldo_off        = (mode_reg == WPC_DEEP);
	assign power_o.boost_converter_off = (mode_reg == WPC_DEEP);

	assign wake_o.wake          = wake_reg;
	assign wake_o.reset_on_wake = wake_reg & dig_reg[DW_RESET];
	assign mode_o               = mode_reg;

endmodule // wpc_top

//--- verif/wpc_props.sv
`timescale 1ns/10ps
// Watches the top ports: bus answers, power controls, resume drive and wake outputs.
module wpc_props import wpc_pkg::*; #(
	parameter int RESUME_LEN = 10
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic        usb_resume_drive_o,
	input wire logic        remote_wake_en_o,
	input wire wpc_power_t  power_o,
	input wire wpc_wake_t   wake_o,
	input wire wpc_mode_t   mode_o
);
	logic       wr_reg;
	logic [7:0] idx_reg;
	logic       rst_on_reg;
	int         hi_cnt;
	wire        kick = wr_reg && idx_reg == IDX_DIG_WAKE && hwdata_i[DW_RESUME];
	// Address phase of each write, so its data phase can be judged.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_reg  <= 1'b0;
			idx_reg <= 8'h00;
		end else begin
			wr_reg  <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
			idx_reg <= haddr_i[9:2];
		end
	end
	// Shadow of the reset-on-wake enable bit.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) rst_on_reg <= 1'b0;
		else if (wr_reg && idx_reg == IDX_DIG_WAKE) rst_on_reg <= hwdata_i[DW_RESET];
	end
	// Counts the cycles the resume drive has stood high.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) hi_cnt <= 0;
		else hi_cnt <= usb_resume_drive_o ? hi_cnt + 1 : 0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence dig_wr; wr_reg && idx_reg == IDX_DIG_WAKE; endsequence
	sequence pda_wr; wr_reg && idx_reg == IDX_PWR_DOWN_A; endsequence
	sequence pdb_wr; wr_reg && idx_reg == IDX_PWR_DOWN_B; endsequence
	AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
		else $error("bus slave not ready or not okay");
	AST_PDA: assert property (pda_wr |=> power_o.pwr_down_a[7] == $past(hwdata_i[7])
		&& power_o.pwr_down_a[4] == $past(hwdata_i[4])) else $error("power down a wrong");
	AST_PDB: assert property (pdb_wr |=> power_o.pwr_down_b[1:0] == $past(hwdata_i[1:0]))
		else $error("power down b wrong");
	AST_DEEP_OFF: assert property ($stable(mode_o) |->
		power_o.core_ldo_off == (mode_o == WPC_DEEP)
		&& power_o.boost_converter_off == (mode_o == WPC_DEEP)) else $error("rails wrong");
	AST_REMOTE: assert property (dig_wr |=> remote_wake_en_o == $past(hwdata_i[DW_REMOTE]))
		else $error("remote wake enable wrong");
	AST_RESUME_CAUSE: assert property ($rose(usb_resume_drive_o) |-> $past(kick)
		|| $past(kick, 2)) else $error("resume drive without request");
	AST_RESUME_LEN: assert property ($fell(usb_resume_drive_o) |-> hi_cnt == RESUME_LEN)
		else $error("resume drive length wrong");
	AST_RESET_ON_WAKE: assert property (wake_o.wake |-> wake_o.reset_on_wake == rst_on_reg)
		else $error("reset on wake wrong");
	AST_WAKE_ASLEEP: assert property (wake_o.wake |-> $past(mode_o) != WPC_ACTIVE)
		else $error("wake while active");
endmodule // wpc_props

bind wpc_top wpc_props #(.RESUME_LEN(RESUME_LEN)) u_props (.clk_i(clk_i), .rst_i(rst_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
	.hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.usb_resume_drive_o(usb_resume_drive_o), .remote_wake_en_o(remote_wake_en_o),
	.power_o(power_o), .wake_o(wake_o), .mode_o(mode_o));

//--- verif/wpc_far_end.sv
`timescale 1ns/10ps
// USB host resume signalling and the external wakeup pins.
module wpc_far_end (
	input  wire logic        clk_i,
	input  wire logic        resume_req_i,
	input  wire logic [35:0] pin_lvl_i,
	output logic             usb_resume_o,
	output logic [35:0]      pins_o
);
	// Idle bus and pins at start.
	initial begin
		usb_resume_o = 1'b0;
		pins_o = 36'h0;
	end
	// Host drives resume while asked; pins take the commanded levels.
	// host resume
	always @(posedge clk_i) begin
		usb_resume_o <= resume_req_i;
		pins_o       <= pin_lvl_i;
	end
endmodule // wpc_far_end

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
	import wpc_pkg::*;
	localparam int RL = 10;
	logic        clk_i, rst_i, hsel, hwrite, res_req, tmr, hrdy, usb, drv, rwe;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic [35:0] lvl, pins;
	wpc_power_t  pwr;
	wpc_wake_t   wk;
	wpc_mode_t   md;
	int          errors, n_checks;
	wpc_top #(.RESUME_LEN(RL)) dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
		.hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
		.hresp_o(), .wake_pins_i(pins), .usb_resume_i(usb), .timer_expired_i(tmr),
		.host_wake_i2c_i(1'b0), .host_wake_spi_i(1'b0), .host_wake_sync_i2c_i(1'b0),
		.gpio_wake_i(1'b0), .usb_resume_drive_o(drv), .remote_wake_en_o(rwe),
		.power_o(pwr), .wake_o(wk), .mode_o(md));
	wpc_far_end far (.clk_i(clk_i), .resume_req_i(res_req), .pin_lvl_i(lvl),
		.usb_resume_o(usb), .pins_o(pins));
	// Clock at 50 MHz.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] ix(input int i);
		case (i)
			11: return IDX_CAUSE;
			12: return IDX_DIG_WAKE;
			13: return IDX_PWR_DOWN_A;
			14: return IDX_PWR_DOWN_B;
			default: return IDX_PA_LEVEL + i[7:0];
		endcase
	endfunction
	function automatic logic [7:0] rstv(input logic [7:0] a);
		return a == IDX_PWR_DOWN_A ? 8'he0 : a == IDX_PWR_DOWN_B ? 8'hdf : 8'h00;
	endfunction
	function automatic logic [7:0] msk(input logic [7:0] a);
		if (a == IDX_PE_LEVEL || a == IDX_PE_ENABLE) return 8'h0f;
		return 8'hff;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, a, 2'b00};
		do @(posedge clk_i); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_i); while (hrdy !== 1'b1);
		// Read data stands through the data phase, so it is taken at the closing edge.
		r = hrdata;
	endtask
	task automatic wcase(input int k, input logic [7:0] m, sen, dig, input logic pol, lv,
		input int cb);
		int p;
		int seen;
		logic rs;
		logic [35:0] v;
		seed = lfsr(seed);
		p = int'(seed[15:0]) % 36;
		v = {seed[3:0], seed};
		v[p] = ~pol;
		lvl <= v;
		bus(1, IDX_SRC_EN, sen, rd);
		bus(1, IDX_DIG_WAKE, dig, rd);
		bus(1, IDX_PA_ENABLE + p[7:0] / 8, 32'h1 << (p % 8), rd);
		bus(1, IDX_PA_LEVEL + p[7:0] / 8, {31'h0, pol} << (p % 8), rd);
		bus(1, IDX_MODE, m, rd);
		@(negedge clk_i);
		chk("ldo_off", m == 8'h02, pwr.core_ldo_off);
		v[p] = lv;
		res_req <= k == 0;
		tmr <= k == 1;
		lvl <= (k == 2) ? v : lvl;
		seen = 0;
		rs = 1'b0;
		repeat (12) begin
			@(negedge clk_i);
			if (wk.wake === 1'b1) begin
				seen = 1;
				rs = wk.reset_on_wake;
			end
		end
		@(posedge clk_i);
		chk("wake", cb >= 0, seen);
		if (seen == 1) chk("reset_on_wake", dig[7], rs);
		res_req <= 1'b0;
		tmr <= 1'b0;
		bus(1, IDX_MODE, 0, rd);
		bus(1, IDX_PA_ENABLE + p[7:0] / 8, 0, rd);
		bus(0, IDX_CAUSE, 0, rd);
		chk("cause", cb >= 0 ? 32'h1 << cb : 32'h0, rd);
		bus(1, IDX_CAUSE, 32'hff, rd);
		bus(0, IDX_CAUSE, 0, rd);
		chk("cause_clr", 0, rd);
	endtask
	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		stop_test();
	end
	// Main sequence.
	initial begin
		{hsel, hwrite, res_req, tmr, htrans, haddr, hwdata, lvl} = '0;
		errors = 0;
		n_checks = 0;
		seed = 32'h18b84607;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 15; i++) begin
			bus(0, ix(i), 0, rd);
			chk("reset_val", rstv(ix(i)), rd);
		end
		bus(1, 8'h7f, 32'hff, rd);
		bus(0, 8'h7f, 0, rd);
		chk("unmapped", 0, rd);
		for (int i = 0; i < 15; i++) begin
			if (i == 11 || i == 12) continue;
			seed = lfsr(seed);
			bus(1, ix(i), seed, rd);
			bus(0, ix(i), 0, rd);
			chk("readback", seed[7:0] & msk(ix(i)), rd);
		end
		for (int i = 0; i < 11; i++) bus(1, ix(i), 0, rd);
		bus(1, IDX_DIG_WAKE, 32'h60, rd);
		@(negedge clk_i);
		chk("resume", 1, drv);
		chk("remote", 1, rwe);
		repeat (RL + 2) @(posedge clk_i);
		chk("resume_end", 0, drv);
		bus(1, IDX_DIG_WAKE, 32'h1b, rd);
		bus(0, IDX_DIG_WAKE, 0, rd);
		chk("dig_en", 32'h1b, rd);
		wcase(0, 1, 8'h20, 8'h04, 0, 0, 2);
		wcase(0, 1, 8'h00, 8'h04, 0, 0, -1);
		wcase(0, 1, 8'h20, 8'h00, 0, 0, -1);
		wcase(0, 2, 8'h20, 8'h04, 0, 0, -1);
		wcase(1, 2, 8'h40, 8'h80, 0, 0, 1);
		wcase(1, 1, 8'h40, 8'h00, 0, 0, 1);
		wcase(1, 1, 8'h00, 8'h00, 0, 0, -1);
		wcase(2, 2, 8'h10, 8'h00, 1, 1, 3);
		wcase(2, 1, 8'h10, 8'h80, 0, 0, 3);
		wcase(2, 1, 8'h10, 8'h00, 1, 0, -1);
		wcase(2, 2, 8'h00, 8'h00, 0, 0, -1);
		stop_test();
	end
endmodule // testbench
